// ---- rtl/tws_eeprom_slave.sv ----
/*
 Two-wire serial slave of a 4096-byte nonvolatile memory: addressing,
 acknowledge, byte and page writes, self-timed write, and reads.
 Assumes ref_clk is far faster than the bus clock; pins are asynchronous.
*/
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_eeprom_slave #(
	parameter int         WRITE_CYCLES = `TWS_WRITE_CYCLES,
	parameter logic [3:0] TYPE_ID      = 4'h5  // Arbitrary value.
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	input  wire logic strap_select_bit2,
	input  wire logic strap_select_bit1,
	input  wire logic strap_select_bit0,
	input  wire logic write_protect,
	output logic      sda_o,
	output logic      sda_oe,
	output logic      standby
);
	tws_pkg::tws_state_e           st;         // Protocol state.
	tws_pkg::tws_state_e           next_st;    // Next protocol state.
	tws_pkg::tws_kind_e            kind;       // Kind of byte received.
	tws_pkg::tws_kind_e            next_kind;  // Next byte kind.
	logic [3:0]                    bit_cnt;    // Bits seen in this byte.
	logic [3:0]                    next_cnt;   // Next bit count.
	logic [7:0]                    shreg;      // Receive shifter.
	logic [7:0]                    next_shreg; // Next receive shifter.
	logic [7:0]                    tx;         // Transmit shifter.
	logic [7:0]                    next_tx;    // Next transmit shifter.
	logic [`TWS_ADDR_W-1:0]        addr;       // Word address counter.
	logic [`TWS_ADDR_W-1:0]        next_addr;  // Next word address.
	logic                          rd_mode;    // Direction bit of last address byte.
	logic                          next_rd;    // Next direction bit.
	logic                          next_oe;    // Next data output enable.
	logic                          wr_pend;    // Page latch holds data.
	logic                          next_wr;    // Next pending flag.
	logic                          ld_en;      // Load data byte into latch.
	logic                          commit;     // Start the self-timed write.
	logic [`TWS_BUSY_W-1:0]        busy_cnt;   // Write cycles remaining.
	logic [2:0]                    strap_s1;   // First strap sync stage.
	logic [2:0]                    strap_s2;   // Synchronised straps.
	logic                          wp_s1;      // First protect sync stage.
	logic                          wp_s2;      // Synchronised write protect.
	logic [7:0]                    rd_data;    // Byte at the counter.

	tws_line_if ln ();

	// Full-array step wraps the last byte to the first; page step keeps the page.
	function automatic logic [`TWS_ADDR_W-1:0] step(
		input logic [`TWS_ADDR_W-1:0] a,
		input logic                   page_only
	);
		logic [`TWS_OFF_W-1:0] off;
		off = a[`TWS_OFF_W-1:0] + 5'h01;
		if (page_only) begin
			step = {a[`TWS_ADDR_W-1:`TWS_OFF_W], off};
		end else begin
			step = a + 12'h001;
		end
	endfunction

	// Decoding of the received byte and of the current situation.
	wire [7:0]              rx_byte   = {shreg[6:0], ln.sda};
	wire                    byte_done = ln.scl_rise && bit_cnt == `TWS_BIT_LAST;
	wire                    busy      = busy_cnt != '0;
	wire                    dev_match = rx_byte[7:4] == TYPE_ID && rx_byte[3:1] == strap_s2
					&& !busy;
	wire                    tx_start  = ln.scl_fall && ((st == tws_pkg::ST_ACK_HOLD
					&& kind == tws_pkg::K_DEV && rd_mode) || st == tws_pkg::ST_TX_NEXT);
	wire [`TWS_ADDR_W-1:0]  addr_seq  = step(addr, 1'b0);
	wire [`TWS_ADDR_W-1:0]  addr_pg   = step(addr, 1'b1);
	wire                    line_evt  = ln.scl_fall || ln.start || ln.stop;
	wire [`TWS_PAGE_W-1:0]  addr_page = addr[`TWS_ADDR_W-1:`TWS_OFF_W];
	wire [`TWS_OFF_W-1:0]   addr_off  = addr[`TWS_OFF_W-1:0];
	wire [`TWS_OFF_W-1:0]   off_nxt   = addr_pg[`TWS_OFF_W-1:0];

	// Bus pin sampler.
	tws_line_sync u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.scl_pin (scl_pin),
		.sda_pin (sda_pin),
		.ln      (ln.drv)
	);

	// Array of 128 pages of 32 bytes with its page latch.
	tws_page_mem u_mem (
		.ref_clk     (ref_clk),
		.nrst        (nrst),
		.rd_addr     (addr),
		.rd_data     (rd_data),
		.ld_en       (ld_en),
		.ld_off      (addr_off),
		.ld_data     (rx_byte),
		.clr         (ln.start),
		.commit      (commit),
		.commit_page (addr_page)
	);

	// Straps and write protect are pins, so they pass two flops.
	always_ff @(posedge ref_clk) begin
		strap_s1 <= {strap_select_bit2, strap_select_bit1, strap_select_bit0};
		strap_s2 <= strap_s1;
		wp_s1    <= write_protect;
		wp_s2    <= wp_s1;
	end

	// Next-state logic of the protocol.
	always_comb begin
		next_st    = st;
		next_kind  = kind;
		next_cnt   = bit_cnt;
		next_shreg = shreg;
		next_tx    = tx;
		next_addr  = addr;
		next_rd    = rd_mode;
		next_oe    = sda_oe;
		next_wr    = wr_pend;
		ld_en      = 1'b0;
		commit     = 1'b0;
		if (ln.stop) begin
			// Stop ends any transfer and goes to ST_IDLE; standby waits for a started write to end.
			next_st = tws_pkg::ST_IDLE;
			next_oe = 1'b0;
			next_wr = 1'b0;
			// Loaded data is stored only when writes are allowed.
			commit = wr_pend && !wp_s2;
		end else if (ln.start) begin
			// Any Start, repeated or after a recovery clocking, expects an address.
			next_st   = tws_pkg::ST_RX;
			next_kind = tws_pkg::K_DEV;
			next_cnt  = `TWS_BIT_RST;
			next_oe   = 1'b0;
			next_wr   = 1'b0;
		end else if (tx_start) begin
			// Load the byte at the counter, drive its top bit, advance the counter.
			next_tx   = rd_data;
			next_oe   = !rd_data[7];
			next_addr = addr_seq;
			next_cnt  = `TWS_BIT_RST;
			next_st   = tws_pkg::ST_TX;
		end else begin
			case (st)
				tws_pkg::ST_RX: begin
					// Receive eight bits, then decide on the acknowledge.
					if (ln.scl_rise) begin
						next_shreg = rx_byte;
						next_cnt   = bit_cnt + 4'h1;
					end
					if (byte_done) begin
						next_st = tws_pkg::ST_ACK_WAIT;
						case (kind)
							tws_pkg::K_DEV: begin
								// Type, straps and idle array must all agree.
								if (!dev_match) begin
									next_st = tws_pkg::ST_IDLE;
								end
								next_rd = rx_byte[0];
							end
							tws_pkg::K_AHI: begin
								// Upper four bits of the first word are ignored.
								next_addr[11:8] = rx_byte[3:0];
							end
							tws_pkg::K_ALO: begin
								next_addr[7:0] = rx_byte;
							end
							default: begin
								// Data goes into the page latch, offset advances in page.
								ld_en     = 1'b1;
								next_wr   = 1'b1;
								next_addr = addr_pg;
							end
						endcase
					end
				end
				tws_pkg::ST_ACK_WAIT: begin
					// Pull data low once the eighth clock has fallen.
					if (ln.scl_fall) begin
						next_oe = 1'b1;
						next_st = tws_pkg::ST_ACK_HOLD;
					end
				end
				tws_pkg::ST_ACK_HOLD: begin
					// Release after the ninth clock; the read path leaves via tx_start.
					if (ln.scl_fall) begin
						next_oe  = 1'b0;
						next_cnt = `TWS_BIT_RST;
						next_st  = tws_pkg::ST_RX;
						if (kind == tws_pkg::K_DEV) begin
							next_kind = tws_pkg::K_AHI;
						end else if (kind == tws_pkg::K_AHI) begin
							next_kind = tws_pkg::K_ALO;
						end else begin
							next_kind = tws_pkg::K_DATA;
						end
					end
				end
				tws_pkg::ST_TX: begin
					// Shift the byte out, changing data only after a falling clock.
					if (ln.scl_rise) begin
						next_cnt = bit_cnt + 4'h1;
					end
					if (ln.scl_fall) begin
						if (bit_cnt == `TWS_BIT_SENT) begin
							next_oe = 1'b0;
							next_st = tws_pkg::ST_TX_ACK;
						end else begin
							next_tx = {tx[6:0], 1'b0};
							next_oe = !tx[6];
						end
					end
				end
				tws_pkg::ST_TX_ACK: begin
					// Master low continues the read; high ends it until the next Start.
					if (ln.scl_rise) begin
						next_st = ln.sda ? tws_pkg::ST_IDLE : tws_pkg::ST_TX_NEXT;
					end
				end
				tws_pkg::ST_TX_NEXT: begin
					// Wait for the ninth clock to fall; the load happens via tx_start.
					next_st = st;
				end
				default: begin
					next_st = tws_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Protocol registers; power-up lands in standby.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st      <= tws_pkg::ST_IDLE;
			kind    <= tws_pkg::K_DEV;
			bit_cnt <= `TWS_BIT_RST;
			addr    <= `TWS_ADDR_RST;
			rd_mode <= 1'b0;
			sda_oe  <= 1'b0;
			wr_pend <= 1'b0;
		end else begin
			st      <= next_st;
			kind    <= next_kind;
			bit_cnt <= next_cnt;
			addr    <= next_addr;
			rd_mode <= next_rd;
			sda_oe  <= next_oe;
			wr_pend <= next_wr;
		end
	end

	// Shifters hold no control meaning, so they need no reset.
	always_ff @(posedge ref_clk) begin
		shreg <= next_shreg;
		tx    <= next_tx;
	end

	// Self-timed write: counts down; while nonzero no address is acknowledged.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			busy_cnt <= '0;
		end else if (commit) begin
			busy_cnt <= `TWS_BUSY_W'(WRITE_CYCLES);
		end else if (busy) begin
			busy_cnt <= busy_cnt - 1'b1;
		end
	end

	// Open-drain data level is always low; standby means idle and no write running.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sda_o   <= 1'b0;
			standby <= 1'b1;
		end else begin
			sda_o   <= 1'b0;
			standby <= st == tws_pkg::ST_IDLE && !busy;
		end
	end

	property p_start_rx;
		@(posedge ref_clk) disable iff (!nrst)
		ln.start |=> st == tws_pkg::ST_RX && kind == tws_pkg::K_DEV && bit_cnt == 4'h0 && !sda_oe;
	endproperty
	a_start_rx: assert property (p_start_rx) else $error("Start did not arm address receive.");

	property p_stop_idle;
		@(posedge ref_clk) disable iff (!nrst)
		ln.stop |=> st == tws_pkg::ST_IDLE && !sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("Stop did not release to standby.");

	property p_edge_only;
		@(posedge ref_clk) disable iff (!nrst)
		$changed(sda_oe) |-> $past(line_evt);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("Data drive changed with clock high.");

	property p_ack_low;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(sda_oe) && st == tws_pkg::ST_ACK_HOLD |-> !sda_o ##1 sda_oe;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("Acknowledge not held low.");

	property p_ack_match;
		@(posedge ref_clk) disable iff (!nrst)
		st == tws_pkg::ST_ACK_HOLD && kind == tws_pkg::K_DEV
			|-> shreg[7:4] == TYPE_ID && shreg[3:1] == strap_s2;
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("Address acknowledged without match.");

	property p_poll;
		@(posedge ref_clk) disable iff (!nrst)
		busy |-> !sda_oe;
	endproperty
	a_poll: assert property (p_poll) else $error("Address acknowledged during write cycle.");

	property p_wp;
		@(posedge ref_clk) disable iff (!nrst)
		ln.stop && wp_s2 && !busy |=> !busy;
	endproperty
	a_wp: assert property (p_wp) else $error("Write started while protected.");

	property p_busy;
		@(posedge ref_clk) disable iff (!nrst)
		commit |=> busy [*8];
	endproperty
	a_busy: assert property (p_busy) else $error("Write cycle did not hold busy.");

	property p_page;
		@(posedge ref_clk) disable iff (!nrst)
		ld_en |=> addr_page == $past(addr_page) && addr_off == $past(off_nxt);
	endproperty
	a_page: assert property (p_page) else $error("Page write address left its page.");

	property p_rd_inc;
		@(posedge ref_clk) disable iff (!nrst)
		tx_start |=> addr == $past(addr_seq) && sda_oe == !tx[7];
	endproperty
	a_rd_inc: assert property (p_rd_inc) else $error("Read did not advance the counter.");
endmodule // tws_eeprom_slave

// ---- include/tws_defines.svh ----
/*
 Constants of the two-wire serial memory slave: array geometry, bit counts,
 reset values and the self-timed write duration.
 Assumes it is included by bare name by every file that needs one of them.
*/
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// Word address width and array size in bytes.
`define TWS_ADDR_W 12
`define TWS_BYTES 4096
// Page geometry: offset width and bytes per page.
`define TWS_OFF_W 5
`define TWS_PAGE_W 7
`define TWS_PAGE_BYTES 32
// Bit counter values: last received bit and end of a sent byte.
`define TWS_BIT_LAST 4'h7
`define TWS_BIT_SENT 4'h8
// Reset values of the word address counter and bit counter.
`define TWS_ADDR_RST 12'h000
`define TWS_BIT_RST 4'h0
// Self-timed write duration in milliseconds and clock rate in kHz.
`define TWS_WRITE_TIME_MS 5
`define TWS_CLK_KHZ 250000
// Cycles of the self-timed write, derived from the two figures above.
`define TWS_WRITE_CYCLES (`TWS_WRITE_TIME_MS * `TWS_CLK_KHZ)
// Width of the write duration counter.
`define TWS_BUSY_W 21

`endif

// ---- include/tws_pkg.sv ----
/*
 Types of the two-wire serial memory slave: protocol states and byte kinds.
 Assumes nothing of its surroundings.
*/
package tws_pkg;

	// Protocol states of the slave.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK_WAIT,
		ST_ACK_HOLD,
		ST_TX,
		ST_TX_ACK,
		ST_TX_NEXT
	} tws_state_e;

	// Meaning of the byte being received.
	typedef enum logic [1:0] {
		K_DEV,
		K_AHI,
		K_ALO,
		K_DATA
	} tws_kind_e;

endpackage

// ---- include/tws_line_if.sv ----
/*
 Line events of the two-wire bus, passed from the sampler to the protocol logic.
 Assumes all signals are single-cycle pulses or levels on ref_clk.
*/
`timescale 1ns/10ps
interface tws_line_if;
	logic scl_rise;  // Clock line went high.
	logic scl_fall;  // Clock line went low.
	logic start;     // Data fell while clock high.
	logic stop;      // Data rose while clock high.
	logic sda;       // Synchronised data level.

	modport drv (output scl_rise, output scl_fall, output start, output stop, output sda);
	modport rcv (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// ---- rtl/tws_line_sync.sv ----
/*
 Samples the bus clock and data pins into ref_clk and finds clock edges and
 Start and Stop conditions.
 Assumes both pins are asynchronous to ref_clk and slower than it by far.
*/
`timescale 1ns/10ps
module tws_line_sync (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	tws_line_if.drv   ln
);
	// Stage 0 is the first synchroniser flop, stage 1 the second, stage 2 history.
	logic [2:0] scl_q;
	logic [2:0] sda_q;

	// Shift both pins through the synchroniser and one history stage.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl_pin};
			sda_q <= {sda_q[1:0], sda_pin};
		end
	end

	// Edges compare the second stage with history only.
	assign ln.scl_rise = scl_q[1] && !scl_q[2];
	assign ln.scl_fall = !scl_q[1] && scl_q[2];
	// A data change while the clock stays high is a Start or a Stop.
	assign ln.start = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
	assign ln.stop = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
	assign ln.sda = sda_q[1];
endmodule // tws_line_sync

// ---- rtl/tws_page_mem.sv ----
/*
 The byte array and the page latch that collects write data until the
 self-timed write stores it.
 Assumes commit and load never coincide and the page stays fixed meanwhile.
*/
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_page_mem (
	input  wire logic                     ref_clk,
	input  wire logic                     nrst,
	input  wire logic [`TWS_ADDR_W-1:0]   rd_addr,
	output logic      [7:0]               rd_data,
	input  wire logic                     ld_en,
	input  wire logic [`TWS_OFF_W-1:0]    ld_off,
	input  wire logic [7:0]               ld_data,
	input  wire logic                     clr,
	input  wire logic                     commit,
	input  wire logic [`TWS_PAGE_W-1:0]   commit_page
);
	logic [7:0]                 arr [0:`TWS_BYTES-1];       // Memory array, no reset.
	logic [7:0]                 page [0:`TWS_PAGE_BYTES-1]; // Page latch.
	logic [`TWS_PAGE_BYTES-1:0] mask;                       // Latch bytes loaded.

	// Reads are combinational from the array.
	assign rd_data = arr[rd_addr];

	// A later byte at the same offset overwrites an earlier one.
	always_ff @(posedge ref_clk) begin
		if (ld_en) begin
			page[ld_off] <= ld_data;
		end
	end

	// Only loaded bytes of the page reach the array.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < `TWS_PAGE_BYTES; i++) begin
			if (commit && mask[i]) begin
				arr[{commit_page, i[`TWS_OFF_W-1:0]}] <= page[i];
			end
		end
	end

	// The mask empties after a store or when a transfer is abandoned.
	always_ff @(posedge ref_clk) begin
		if (!nrst || clr || commit) begin
			mask <= '0;
		end else if (ld_en) begin
			mask[ld_off] <= 1'b1;
		end
	end
endmodule // tws_page_mem

// ---- verification/tws_bus_master.sv ----
/*
 Bus master model of the two-wire link: Start, Stop, bit and byte transfers.
 Assumes an external pull-up: the data wire is low only while someone drives it.
*/
`timescale 1ns/10ps
module tws_bus_master (
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      m_oe
);
	// The bus starts idle with both lines released high.
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end

	// Waits n edges so every change lands just after a rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Data falls while the clock is high, then the clock drops.
	task automatic start();
		tick(3);
		m_oe <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(6);
		m_oe <= 1'b1;
		tick(6);
		scl <= 1'b0;
	endtask

	// Data rises while the clock is high; the bus is left idle.
	task automatic stop();
		tick(3);
		m_oe <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(6);
		m_oe <= 1'b0;
		tick(6);
	endtask

	// One clock of 12 edges, a 48 ns period: data set mid-low, sampled mid-high.
	task automatic bit_io(input logic b, output logic r);
		tick(3);
		m_oe <= ~b;
		tick(3);
		scl <= 1'b1;
		tick(3);
		r = sda;
		tick(3);
		scl <= 1'b0;
	endtask

	// Eight bits MSB first, then the ninth clock carries the acknowledge.
	task automatic byte_io(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_in, ack);
	endtask

	// Protocol reset after an interrupted transfer.
	task automatic recover();
		logic r;
		start();
		for (int i = 0; i < 9; i++) begin
			bit_io(1'b1, r);
		end
		start();
		stop();
	endtask
endmodule // tws_bus_master

// ---- verification/tws_eeprom_slave_tb.sv ----
/*
 Self-checking bench of the two-wire memory slave driven by the master model.
 Assumes a shortened self-timed write of 600 reference clocks.
*/
`timescale 1ns/10ps
module tws_eeprom_slave_tb;
	localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary value.
	logic       ref_clk;     // Reference clock.
	logic       nrst;        // Synchronous reset, active low.
	logic [2:0] straps;      // Address strap pins.
	logic       wp;          // Write protect input.
	logic       scl;         // Bus clock from the master.
	logic       m_oe;        // Master pulls data low.
	wire        sda;         // Resolved data wire with pull-up.
	wire        dut_oe;      // Slave pulls data low.
	wire        dut_o;       // Slave data level while driving.
	wire        standby;     // Slave idle flag.
	int         fail_count;  // Mismatches seen.
	int         checks;      // Comparisons made.
	int         polls;       // Address attempts of the last poll.

	assign sda = (dut_oe ? dut_o : 1'b1) & ~m_oe;

	tws_bus_master mdl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .m_oe(m_oe));

	tws_eeprom_slave #(.WRITE_CYCLES(600), .TYPE_ID(TYPE_ID)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .scl_pin(scl), .sda_pin(sda),
		.strap_select_bit2(straps[2]), .strap_select_bit1(straps[1]),
		.strap_select_bit0(straps[0]), .write_protect(wp),
		.sda_o(dut_o), .sda_oe(dut_oe), .standby(standby));

	// 250 MHz reference clock.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compares one value against its expectation.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] dev(input logic rw);
		return {TYPE_ID, straps, rw};
	endfunction

	// Sends a byte and checks the slave's acknowledge.
	task automatic send(input logic [7:0] d, input logic exp_ack);
		logic [7:0] q;
		logic       a;
		mdl.byte_io(d, 1'b1, q, a);
		chk({7'h00, a}, {7'h00, exp_ack});
	endtask

	// Reads a byte, answers with m_ack and checks the data.
	task automatic rd(input logic m_ack, input logic [7:0] exp);
		logic [7:0] q;
		logic       a;
		mdl.byte_io(8'hff, m_ack, q, a);
		chk(q, exp);
	endtask

	// Repeats Start and address until acknowledged, under a bound.
	task automatic poll(input logic rw);
		logic [7:0] q;
		logic       a;
		for (polls = 1; polls <= 12; polls++) begin
			mdl.start();
			mdl.byte_io(dev(rw), 1'b1, q, a);
			if (a === 1'b0) begin
				return;
			end
		end
		fail_count++;
		$display("MISMATCH t=%0t poll bound used up seen=%h exp=%h", $time, a, 1'b0);
		end_of_test();
	endtask

	// Loads a word address; the top nibble of the high byte is junk.
	task automatic set_addr(input logic [11:0] a);
		poll(1'b0);
		send({4'h9, a[11:8]}, 1'b0);
		send(a[7:0], 1'b0);
	endtask

	// Repeated Start with the read direction.
	task automatic rd_start();
		mdl.start();
		send(dev(1'b1), 1'b0);
	endtask

	// Idle state after reset.
	task automatic t_idle();
		chk({7'h00, standby}, 8'h01);
		chk({7'h00, dut_oe}, 8'h00);
		$display("test idle done");
	endtask

	// Wrong type nibble or straps get no acknowledge.
	task automatic t_refuse();
		for (int i = 0; i < 4; i++) begin
			mdl.start();
			send(dev(1'b0) ^ ((i == 0) ? 8'h80 : (8'h10 >> i)), 1'b1);
			mdl.tick(4);
			chk({7'h00, standby}, 8'h01);
			mdl.stop();
		end
		$display("test refuse done");
	endtask

	// 34 bytes into one page from offset 30, busy polling, read back.
	task automatic t_page();
		logic [7:0] e;
		set_addr({7'h5b, 5'd30});
		for (int i = 0; i < 34; i++) begin
			send(8'h40 + i[7:0], 1'b0);
		end
		mdl.stop();
		mdl.tick(4);
		chk({7'h00, standby}, 8'h00);
		set_addr({7'h5b, 5'd0});
		chk({7'h00, polls > 1}, 8'h01);
		rd_start();
		for (int o = 0; o < 32; o++) begin
			e = (o < 30) ? 8'h42 + o[7:0] : 8'h60 + o[7:0] - 8'd30;
			rd(o == 31, e);
		end
		mdl.stop();
		$display("test page done");
	endtask

	// Byte writes at the array ends, wrapping and current-address reads.
	task automatic t_wrap();
		set_addr(12'hfff);
		send(8'hc3, 1'b0);
		mdl.stop();
		set_addr(12'h000);
		send(8'hc4, 1'b0);
		send(8'hc5, 1'b0);
		mdl.stop();
		set_addr(12'hfff);
		rd_start();
		rd(1'b0, 8'hc3);
		rd(1'b1, 8'hc4);
		mdl.stop();
		mdl.tick(4);
		chk({7'h00, standby}, 8'h01);
		rd_start();
		rd(1'b1, 8'hc5);
		mdl.stop();
		$display("test wrap done");
	endtask

	// A write with protection high leaves the byte unchanged.
	task automatic t_protect();
		wp <= 1'b1;
		set_addr(12'hfff);
		send(8'h11, 1'b0);
		mdl.stop();
		set_addr(12'hfff);
		wp <= 1'b0;
		rd_start();
		rd(1'b1, 8'hc3);
		mdl.stop();
		$display("test protect done");
	endtask

	// A read cut short, then the protocol reset restores addressing.
	task automatic t_recover();
		logic r;
		set_addr(12'h000);
		rd_start();
		for (int i = 0; i < 3; i++) begin
			mdl.bit_io(1'b1, r);
		end
		mdl.recover();
		mdl.start();
		send(dev(1'b0), 1'b0);
		mdl.stop();
		// A strapless part: all three select bits are sent as zero.
		straps <= 3'b000;
		mdl.start();
		send(dev(1'b0), 1'b0);
		mdl.stop();
		$display("test recover done");
	endtask

	// Main sequence: reset for 12 cycles, then the scenarios.
	initial begin
		nrst = 1'b0;
		wp = 1'b0;
		straps = 3'b101;
		fail_count = 0;
		checks = 0;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_idle();
		t_refuse();
		t_page();
		t_wrap();
		t_protect();
		t_recover();
		end_of_test();
	end

	// Cuts a hang short.
	initial begin
		repeat (95000) @(posedge ref_clk);
		fail_count++;
		$display("MISMATCH t=%0t run bound used up", $time);
		end_of_test();
	end
endmodule // tws_eeprom_slave_tb
